// file: rtl/cbcr_pkg.sv
package cbcr_pkg;

    // ************************************************************
    // Channel count and register map
    // ************************************************************
    localparam int          CBCR_NUM_CH        = 4;
    localparam logic [5:0]  CBCR_ADDR_UPPER    = 6'h36;
    localparam logic [7:0]  CBCR_OFF_POLARITY  = 8'h00;
    localparam logic [7:0]  CBCR_OFF_DECODE    = 8'h01;
    localparam logic [7:0]  CBCR_OFF_PRIORITY  = 8'h02;
    localparam logic [7:0]  CBCR_OFF_DRIVE     = 8'h03;

    // ************************************************************
    // Power-up values
    // ************************************************************
    localparam logic [7:0]  CBCR_RST_POLARITY  = 8'h9F;
    localparam logic [7:0]  CBCR_RST_DECODE    = 8'hF0;
    localparam logic [7:0]  CBCR_RST_PRIORITY  = 8'h09;
    localparam logic [7:0]  CBCR_RST_DRIVE     = 8'h00;

    // ************************************************************
    // Writable bits and bits set by the reset pin
    // ************************************************************
    localparam logic [7:0]  CBCR_WMASK_POLARITY = 8'hFF;
    localparam logic [7:0]  CBCR_WMASK_DECODE   = 8'hFC;
    localparam logic [7:0]  CBCR_WMASK_PRIORITY = 8'hFF;
    localparam logic [7:0]  CBCR_WMASK_DRIVE    = 8'hF0;
    localparam logic [7:0]  CBCR_PIN_SET_POLARITY = 8'h90;
    localparam logic [7:0]  CBCR_PIN_SET_PRIORITY = 8'h09;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          CBCR_INTREQ_LSB    = 4;
    localparam int          CBCR_POL_LSB       = 0;
    localparam int          CBCR_DECSEL_LSB    = 4;
    localparam int          CBCR_OUTTYPE_HI    = 3;
    localparam int          CBCR_OUTTYPE_LO    = 2;
    localparam int          CBCR_OVERRIDE_HI   = 7;
    localparam int          CBCR_OVERRIDE_LO   = 6;
    localparam int          CBCR_REGMODE_HI    = 5;
    localparam int          CBCR_REGMODE_LO    = 4;
    localparam int          CBCR_SRCSEL_LSB    = 0;
    localparam int          CBCR_DRIVE_LSB     = 4;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CBCR_CLK_PERIOD_NS = 20;
    localparam int          CBCR_RST_FILTER_NS = 500;
    // Strictly longer than the filter time, so one cycle beyond it.
    localparam int          CBCR_RST_FILTER_CYCLES =
        (CBCR_RST_FILTER_NS + CBCR_CLK_PERIOD_NS) / CBCR_CLK_PERIOD_NS;

    // ************************************************************
    // Serial slave states
    // ************************************************************
    typedef enum logic [3:0] {
        CBCR_IDLE,
        CBCR_ADDR,
        CBCR_ACK_ADDR,
        CBCR_OFFSET,
        CBCR_ACK_OFFSET,
        CBCR_WDATA,
        CBCR_ACK_WDATA,
        CBCR_RDATA,
        CBCR_RACK
    } cbcr_state_type;

endpackage

// file: rtl/cbcr_sync.sv
`timescale 1ns/1ps

module cbcr_sync #(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // cbcr_sync

// file: rtl/cbcr_rst_filter.sv
`timescale 1ns/1ps

module cbcr_rst_filter
    import cbcr_pkg::*;
#(
    parameter int FILTER_CYCLES = CBCR_RST_FILTER_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic level_n,
    output logic      reset_pulse
);

    localparam int CW = $clog2(FILTER_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES);

    logic [CW-1:0] low_cnt_q;

    // Spikes shorter than the filter time never reach the count.
    always_ff @(posedge clk) begin
        if (rst || level_n) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != LAST) begin
            low_cnt_q <= low_cnt_q + CW'(1);
        end
    end

    // One pulse per low period, however long it lasts.
    always_ff @(posedge clk) begin
        if (rst) begin
            reset_pulse <= 1'b0;
        end else begin
            reset_pulse <= !level_n && (low_cnt_q == LAST - CW'(1));
        end
    end

endmodule // cbcr_rst_filter

// file: rtl/cbcr_regs.sv
`timescale 1ns/1ps

// Summary of operation
// - Serial slave only, fast mode, 7-bit address.
// - Works with slower bus participants too.
// - Single byte reads and writes only.
// - Written byte takes effect immediately.
// - Address 110110 plus select pin bit.
// - Bytes shift most significant bit first.
// - Source bit chooses pin or internal request.
// - Polarity bits set request active level.
// - Select bits include requests in decoding.
// - Output type: wired-OR, wired-AND, push-pull.
// - Override forces master request low or high.
// - Regulator on, off, or decoder controlled.
// - Drive strength bits per output.
// - Reset pin sets channel one/four bits.
// - Power-up restores every default value.
// - Reset pin needs over 500 ns low.

module cbcr_regs
    import cbcr_pkg::*;
#(
    parameter int NUM_CH        = CBCR_NUM_CH,
    parameter int FILTER_CYCLES = CBCR_RST_FILTER_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              serial_clock_line,
    input  wire logic              serial_data_line_i,
    output logic                   serial_data_line_o,
    output logic                   serial_data_line_oe,
    input  wire logic              address_select_input,
    input  wire logic              config_reset_n,
    input  wire logic [NUM_CH-1:0] clock_request_input,
    output logic      [NUM_CH-1:0] buffered_clock_enable,
    output logic      [NUM_CH-1:0] drive_strength,
    output logic                   voltage_regulator_enable,
    output logic                   master_request_o,
    output logic                   master_request_oe
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    localparam int SW = NUM_CH + 4;
    localparam logic [SW-1:0] SYNC_RST = {3'b111, 1'b0, {NUM_CH{1'b0}}};

    logic [SW-1:0]     pins_s;
    logic              scl_s;
    logic              sda_s;
    logic              addr_sel_s;
    logic              cfg_rst_n_s;
    logic [NUM_CH-1:0] req_s;
    logic              pin_reset_pulse;

    cbcr_sync #(
        .WIDTH     (SW),
        .RESET_VAL (SYNC_RST)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({config_reset_n, serial_clock_line, serial_data_line_i,
                    address_select_input, clock_request_input}),
        .sync_out (pins_s)
    );

    assign cfg_rst_n_s = pins_s[SW-1];
    assign scl_s       = pins_s[SW-2];
    assign sda_s       = pins_s[SW-3];
    assign addr_sel_s  = pins_s[SW-4];
    assign req_s       = pins_s[NUM_CH-1:0];

    cbcr_rst_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_rst_filter (
        .clk         (clk),
        .rst         (rst),
        .level_n     (cfg_rst_n_s),
        .reset_pulse (pin_reset_pulse)
    );

    // ************************************************************
    // Bus events
    // ************************************************************
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Edges are found by sampling, so any bus speed up to the fast
    // mode is followed without knowing the rate in advance.
    assign scl_rise  = scl_s && !scl_prev_q;
    assign scl_fall  = !scl_s && scl_prev_q;
    assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign bus_stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;

    // ************************************************************
    // Register file helpers
    // ************************************************************
    logic [7:0] polarity_q;
    logic [7:0] decode_q;
    logic [7:0] priority_q;
    logic [7:0] drive_q;

    function automatic logic [7:0] write_mask(input logic [7:0] off);
        unique case (off)
            CBCR_OFF_POLARITY: write_mask = CBCR_WMASK_POLARITY;
            CBCR_OFF_DECODE:   write_mask = CBCR_WMASK_DECODE;
            CBCR_OFF_PRIORITY: write_mask = CBCR_WMASK_PRIORITY;
            CBCR_OFF_DRIVE:    write_mask = CBCR_WMASK_DRIVE;
            default:           write_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] off,
        input logic [7:0] r0, r1, r2, r3);
        unique case (off)
            CBCR_OFF_POLARITY: read_reg = r0;
            CBCR_OFF_DECODE:   read_reg = r1;
            CBCR_OFF_PRIORITY: read_reg = r2;
            CBCR_OFF_DRIVE:    read_reg = r3;
            default:           read_reg = 8'h00;
        endcase
    endfunction

    // ************************************************************
    // Serial slave
    // ************************************************************
    cbcr_state_type state_q;
    logic [7:0]     shift_q;
    logic [2:0]     bit_cnt_q;
    logic [7:0]     offset_q;
    logic           ack_q;
    logic           ack_phase_q;
    logic           rw_q;
    logic           wr_en_q;
    logic [7:0]     wr_data_q;
    logic [7:0]     full_byte;
    logic [7:0]     rd_byte;

    assign full_byte = {shift_q[6:0], sda_s};
    assign rd_byte   = read_reg(offset_q, polarity_q, decode_q,
                                priority_q, drive_q);

    // The line is only ever pulled low; a one is a released line.
    assign serial_data_line_o = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q             <= CBCR_IDLE;
            shift_q             <= 8'h00;
            bit_cnt_q           <= 3'h0;
            offset_q            <= 8'h00;
            ack_q               <= 1'b0;
            ack_phase_q         <= 1'b0;
            rw_q                <= 1'b0;
            wr_en_q             <= 1'b0;
            wr_data_q           <= 8'h00;
            serial_data_line_oe <= 1'b0;
        end else begin
            wr_en_q <= 1'b0;
            if (bus_start) begin
                state_q             <= CBCR_ADDR;
                bit_cnt_q           <= 3'h0;
                ack_phase_q         <= 1'b0;
                serial_data_line_oe <= 1'b0;
            end else if (bus_stop) begin
                state_q             <= CBCR_IDLE;
                serial_data_line_oe <= 1'b0;
            end else begin
                unique case (state_q)
                    CBCR_IDLE: serial_data_line_oe <= 1'b0;
                    CBCR_ADDR, CBCR_OFFSET, CBCR_WDATA: begin
                        if (scl_rise) begin
                            shift_q   <= full_byte;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7) begin
                                ack_q <= 1'b1;
                                if (state_q == CBCR_ADDR) begin
                                    // Master codes and other slaves
                                    // get no answer.
                                    ack_q   <= full_byte[7:1] ==
                                        {CBCR_ADDR_UPPER, addr_sel_s};
                                    rw_q    <= full_byte[0];
                                    state_q <= CBCR_ACK_ADDR;
                                end else if (state_q == CBCR_OFFSET) begin
                                    offset_q <= full_byte;
                                    state_q  <= CBCR_ACK_OFFSET;
                                end else begin
                                    wr_en_q   <= 1'b1;
                                    wr_data_q <= full_byte;
                                    state_q   <= CBCR_ACK_WDATA;
                                end
                            end
                        end
                    end
                    CBCR_ACK_ADDR, CBCR_ACK_OFFSET, CBCR_ACK_WDATA: begin
                        if (scl_fall && !ack_phase_q) begin
                            serial_data_line_oe <= ack_q;
                            ack_phase_q         <= 1'b1;
                        end else if (scl_fall) begin
                            ack_phase_q         <= 1'b0;
                            serial_data_line_oe <= 1'b0;
                            bit_cnt_q           <= 3'h0;
                            if (!ack_q) begin
                                state_q <= CBCR_IDLE;
                            end else if (state_q == CBCR_ACK_ADDR && rw_q) begin
                                serial_data_line_oe <= !rd_byte[7];
                                shift_q             <= {rd_byte[6:0], 1'b0};
                                state_q             <= CBCR_RDATA;
                            end else if (state_q == CBCR_ACK_ADDR) begin
                                state_q <= CBCR_OFFSET;
                            end else if (state_q == CBCR_ACK_OFFSET) begin
                                state_q <= CBCR_WDATA;
                            end else begin
                                // A second data byte is left unanswered.
                                state_q <= CBCR_IDLE;
                            end
                        end
                    end
                    CBCR_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7) begin
                                state_q <= CBCR_RACK;
                            end
                        end else if (scl_fall) begin
                            serial_data_line_oe <= !shift_q[7];
                            shift_q             <= {shift_q[6:0], 1'b0};
                        end
                    end
                    CBCR_RACK: begin
                        if (scl_fall) begin
                            serial_data_line_oe <= 1'b0;
                        end else if (scl_rise) begin
                            bit_cnt_q <= 3'h0;
                            if (sda_s) begin
                                state_q <= CBCR_IDLE;
                            end else begin
                                // A master that acks gets the same
                                // register again, never the next one.
                                shift_q <= rd_byte;
                                state_q <= CBCR_RDATA;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Offsets above three are accepted on the bus but store nothing,
    // so a stray write cannot disturb the outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            polarity_q <= CBCR_RST_POLARITY;
            decode_q   <= CBCR_RST_DECODE;
            priority_q <= CBCR_RST_PRIORITY;
            drive_q    <= CBCR_RST_DRIVE;
        end else begin
            if (wr_en_q) begin
                unique case (offset_q)
                    CBCR_OFF_POLARITY: polarity_q <=
                        wr_data_q & write_mask(offset_q);
                    CBCR_OFF_DECODE:   decode_q   <=
                        wr_data_q & write_mask(offset_q);
                    CBCR_OFF_PRIORITY: priority_q <=
                        wr_data_q & write_mask(offset_q);
                    CBCR_OFF_DRIVE:    drive_q    <=
                        wr_data_q & write_mask(offset_q);
                    default: ;
                endcase
            end
            if (pin_reset_pulse) begin
                polarity_q <= (wr_en_q && offset_q == CBCR_OFF_POLARITY ?
                    wr_data_q : polarity_q) | CBCR_PIN_SET_POLARITY;
                priority_q <= (wr_en_q && offset_q == CBCR_OFF_PRIORITY ?
                    wr_data_q : priority_q) | CBCR_PIN_SET_PRIORITY;
            end
        end
    end

    // ************************************************************
    // Request decoding and outputs
    // ************************************************************
    logic [NUM_CH-1:0] req_active;
    logic [NUM_CH-1:0] chan_enable;
    logic              decoded_req;
    logic              master_req_level;
    logic [1:0]        out_type;
    logic [1:0]        override;
    logic [1:0]        reg_mode;

    assign out_type = {decode_q[CBCR_OUTTYPE_HI], decode_q[CBCR_OUTTYPE_LO]};
    assign override = priority_q[CBCR_OVERRIDE_HI:CBCR_OVERRIDE_LO];
    assign reg_mode = priority_q[CBCR_REGMODE_HI:CBCR_REGMODE_LO];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            req_active[i]  = req_s[i] ~^ polarity_q[CBCR_POL_LSB + i];
            chan_enable[i] = priority_q[CBCR_SRCSEL_LSB + i] ?
                polarity_q[CBCR_INTREQ_LSB + i] : req_active[i];
        end
    end

    assign decoded_req = |(req_active &
        decode_q[CBCR_DECSEL_LSB +: NUM_CH]);
    assign master_req_level = override[1] ? override[0] : decoded_req;

    always_ff @(posedge clk) begin
        if (rst) begin
            buffered_clock_enable <= '0;
            drive_strength        <= '0;
        end else begin
            buffered_clock_enable <= chan_enable;
            drive_strength        <= drive_q[CBCR_DRIVE_LSB +: NUM_CH];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            voltage_regulator_enable <= 1'b1;
        end else begin
            unique case (reg_mode)
                2'h0:    voltage_regulator_enable <= 1'b1;
                2'h1:    voltage_regulator_enable <= 1'b0;
                default: voltage_regulator_enable <= decoded_req;
            endcase
        end
    end

    // Wired-OR drives only the asserting level and wired-AND only the
    // idle level, releasing the other, so devices can share the request line.
    always_ff @(posedge clk) begin
        if (rst) begin
            master_request_o  <= 1'b0;
            master_request_oe <= 1'b0;
        end else begin
            unique case (out_type)
                2'h0:    {master_request_o, master_request_oe} <=
                             {1'b1, master_req_level};
                2'h1:    {master_request_o, master_request_oe} <=
                             {1'b0, !master_req_level};
                default: {master_request_o, master_request_oe} <=
                             {master_req_level, 1'b1};
            endcase
        end
    end

endmodule // cbcr_regs

// file: sim/cbcr_regs_properties.sv
`timescale 1ns/1ps
module cbcr_regs_properties
    import cbcr_pkg::*;
#(
    parameter int NUM_CH        = CBCR_NUM_CH,
    parameter int FILTER_CYCLES = CBCR_RST_FILTER_CYCLES
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              serial_clock_line,
    input wire logic              serial_data_line_o,
    input wire logic              serial_data_line_oe,
    input wire logic              config_reset_n,
    input wire logic [NUM_CH-1:0] clock_request_input,
    input wire logic [NUM_CH-1:0] buffered_clock_enable,
    input wire logic [NUM_CH-1:0] drive_strength,
    input wire logic              voltage_regulator_enable,
    input wire logic              master_request_o,
    input wire logic              master_request_oe
);
    // ****
    // Cause counters
    // ****
    // Outputs move only soon after a bus, request or reset pin event, so a
    // register that drifts by itself is caught.
    logic [5:0] bus_q;
    logic [5:0] any_q;
    always_ff @(posedge clk)
        if (rst || $changed(serial_clock_line)) bus_q <= 6'h00;
        else if (bus_q != 6'h3F) bus_q <= bus_q + 6'h01;
    always_ff @(posedge clk)
        if (rst || $changed(serial_clock_line) || !config_reset_n ||
            $changed(clock_request_input)) any_q <= 6'h00;
        else if (any_q != 6'h3F) any_q <= any_q + 6'h01;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RST_OUT:
    assert property ($fell(rst) |-> buffered_clock_enable == '0 &&
        drive_strength == '0 && !master_request_oe && !serial_data_line_oe)
        else $error("outputs not cleared by reset");
    AST_REG_ON:
    assert property ($fell(rst) |-> voltage_regulator_enable)
        else $error("regulator off after reset");
    AST_OPEN_DRAIN:
    assert property (serial_data_line_o == 1'b0)
        else $error("data line driven high");
    AST_ACK_ON_LOW:
    assert property ($changed(serial_data_line_oe) |->
        !$past(serial_clock_line)) else $error("data moved in clock high");
    AST_ACK_STANDS:
    assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe[*3])
        else $error("data drive too short");
    AST_DRIVE_BUS:
    assert property ($changed(drive_strength) |-> bus_q < 6'h0C)
        else $error("drive changed without a write");
    AST_EN_CAUSE:
    assert property ($changed(buffered_clock_enable) |-> any_q < 6'h0C)
        else $error("enable changed without cause");
    AST_MREQ_CAUSE:
    assert property ($changed({master_request_o, master_request_oe,
        voltage_regulator_enable}) |-> any_q < 6'h0C)
        else $error("request changed without cause");
    cover property ($rose(serial_data_line_oe));
    cover property ($changed(drive_strength));
    cover property ($rose(master_request_oe));
endmodule // cbcr_regs_properties

bind cbcr_regs cbcr_regs_properties #(
    .NUM_CH(NUM_CH), .FILTER_CYCLES(FILTER_CYCLES)
) chk (
    .clk, .rst, .serial_clock_line, .serial_data_line_o,
    .serial_data_line_oe, .config_reset_n, .clock_request_input,
    .buffered_clock_enable, .drive_strength, .voltage_regulator_enable,
    .master_request_o, .master_request_oe
);

// file: sim/cbcr_master_model.sv
`timescale 1ns/1ps
module cbcr_master_model (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_low,
    output logic            rd_valid,
    output logic [7:0]      rd_data
);
    // ****
    // Serial bus master
    // ****
    // Data moves a clock after the clock line falls, so no false start.
    logic a0 = 1'b0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    task automatic half(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        rd_valid <= 1'b0;
        @(posedge clk);
        sda_low <= ~d;
        repeat (2) @(posedge clk);
    endtask
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            half(1'b0, tx[i]);
            half(1'b1, tx[i]);
            rx[i] = sda;
        end
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
    endtask
    task automatic frame(input logic [7:0] off, input logic [7:0] v,
                         input logic rd);
        logic [7:0] r;
        half(1'b1, 1'b0);
        byte_x({6'h36, a0, 1'b0}, r);
        byte_x(off, r);
        if (rd) begin
            half(1'b0, 1'b1);
            half(1'b1, 1'b1);
            half(1'b1, 1'b0);
            byte_x({6'h36, a0, 1'b1}, r);
            byte_x(8'hFF, r);
            rd_data <= r;
            rd_valid <= 1'b1;
        end else byte_x(v, r);
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
        half(1'b1, 1'b1);
    endtask
endmodule // cbcr_master_model

// file: sim/cbcr_regs_bench.sv
`timescale 1ns/1ps
module cbcr_regs_bench;
    // ****
    // Stimulus and checking
    // ****
    logic       clk, rst, rst_n, sel, scl, sda_low, rd_valid;
    logic       sda_oe, reg_en, mr_o, mr_oe, lvl, dec;
    logic [3:0] req, en, drv;
    logic [7:0] rd_data, d, r3;
    logic [7:0] dflt [4] = '{8'h9F, 8'hF0, 8'h09, 8'h00};
    logic [7:0] wmsk [4] = '{8'hFF, 8'hFC, 8'hFF, 8'hF0};
    logic [7:0] exp_q [$];
    int         n_mismatch = 0;
    int         check_count = 0;
    wire        sda = ~(sda_low | sda_oe);
    cbcr_regs #(.FILTER_CYCLES(4)) dut (
        .clk(clk), .rst(rst), .serial_clock_line(scl),
        .serial_data_line_i(sda), .serial_data_line_o(),
        .serial_data_line_oe(sda_oe), .address_select_input(sel),
        .config_reset_n(rst_n), .clock_request_input(req),
        .buffered_clock_enable(en), .drive_strength(drv),
        .voltage_regulator_enable(reg_en), .master_request_o(mr_o),
        .master_request_oe(mr_oe));
    cbcr_master_model mdl (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low), .rd_valid(rd_valid), .rd_data(rd_data));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] off, input logic [7:0] v);
        exp_q.push_back(v);
        mdl.frame(off, 8'h00, 1'b1);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) if (rd_valid) check(rd_data, exp_q.pop_front());
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        rst_n = 1'b1;
        sel = 1'b0;
        req = 4'h0;
        void'($urandom(48025));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) rd(i, dflt[i]);
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            if (i == 3) r3 = d & 8'hF0;
            if (i < 4) mdl.frame(i, d, 1'b0);
            rd(i, i < 4 ? d & wmsk[i] : 8'h00);
        end
        check(drv, r3[7:4]);
        mdl.a0 = 1'b1;
        mdl.frame(8'h03, ~r3, 1'b0);
        sel <= 1'b1;
        rd(8'h03, r3);
        mdl.a0 = 1'b0;
        sel <= 1'b0;
        mdl.frame(8'h02, 8'h0F, 1'b0);
        d = $urandom;
        mdl.frame(8'h00, {d[7:4], 4'hF}, 1'b0);
        check(en, d[7:4]);
        mdl.frame(8'h02, 8'h00, 1'b0);
        for (int p = 0; p < 2; p++) begin
            mdl.frame(8'h00, {4'h0, {4{p[0]}}}, 1'b0);
            req <= 4'($urandom);
            repeat (8) @(posedge clk);
            check(en, p ? req : {~req});
        end
        mdl.frame(8'h00, 8'h0F, 1'b0);
        for (int k = 0; k < 16; k++) begin
            d = $urandom;
            req <= d[3:0];
            mdl.frame(8'h01, {d[7:4], k[1:0], 2'b00}, 1'b0);
            mdl.frame(8'h02, {k[3:2], k[3:2], 4'h0}, 1'b0);
            dec = |(d[3:0] & d[7:4]);
            lvl = k[3] ? k[2] : dec;
            check({reg_en, mr_o, mr_oe}, {k[3] ? dec : ~k[2], k[1] ?
                {lvl, 1'b1} : {~k[0], lvl ^ k[0]}});
        end
        mdl.frame(8'h00, 8'h00, 1'b0);
        mdl.frame(8'h02, 8'h00, 1'b0);
        for (int w = 2; w < 15; w += 12) begin
            rst_n <= 1'b0;
            repeat (w) @(posedge clk);
            rst_n <= 1'b1;
            repeat (20) @(posedge clk);
            rd(8'h00, w > 4 ? 8'h90 : 8'h00);
        end
        rd(8'h02, 8'h09);
        rd(8'h03, r3);
        give_verdict();
    end
endmodule // cbcr_regs_bench
